/* File: serial_flash_powerup_cmd_front_bench.sv */
// testbench joining host and device ends of the command front
`timescale 1ns/100ps
module serial_flash_powerup_cmd_front_bench;
    import sfc_pkg::*;
    logic        core_clk_in = 1'b0;
    logic        reset_in    = 1'b1;
    logic        por         = 1'b0;
    logic        start       = 1'b0;
    logic        mode3       = 1'b0;
    sfc_op_t     opcode      = 8'h00;
    logic [11:0] page        = 12'h000;
    logic [8:0]  byte_addr   = 9'h000;
    logic        tx_en       = 1'b0;
    logic        dv_valid, dv_m3, standby, prog_ok;
    sfc_op_t     dv_op;
    logic [11:0] dv_page;
    logic [8:0]  dv_byte;
    logic        busy, done, refused, ready, prog_ready;
    logic [7:0]  rx_byte;
    int          n_mismatch = 0;
    int          total_checks = 0;
    int          n_valid = 0;
    int          cyc = 0;
    int          nh = 0;

    sfc_spi_if spi ();
    sfc_device #(.PUW_CYC(200)) i_sfc_device (.core_clk_in(core_clk_in), .reset_in(reset_in),
        .power_on_reset_in(por), .spi(spi), .tx_byte_in(8'ha5), .tx_enable_in(tx_en),
        .cmd_valid_out(dv_valid), .opcode_out(dv_op), .page_out(dv_page), .byte_out(dv_byte),
        .mode3_out(dv_m3), .standby_out(standby), .prog_allowed_out(prog_ok));
    sfc_host #(.VCSL_CYC(50), .PUW_CYC(200), .HALF_DIV(2)) i_sfc_host (
        .core_clk_in(core_clk_in), .reset_in(reset_in), .spi(spi), .start_in(start),
        .mode3_in(mode3), .opcode_in(opcode), .page_in(page), .byte_in(byte_addr),
        .busy_out(busy), .done_out(done), .refused_out(refused), .ready_out(ready),
        .prog_ready_out(prog_ready), .rx_byte_out(rx_byte));
    sfc_asserts i_sfc_asserts (.core_clk_in(core_clk_in), .reset_in(reset_in), .sclk(spi.sclk),
        .si(spi.si), .select_n_pin(spi.select_n_pin), .so_data(spi.so_data), .so_oe(spi.so_oe));

    // ------------------------------------------------------------
    // clock, pulse count and hang guard
    // ------------------------------------------------------------
    always #2.5 core_clk_in = ~core_clk_in;
    always @(posedge core_clk_in) begin
        cyc <= cyc + 1;
        if (dv_valid === 1'b1) n_valid <= n_valid + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            complete_run();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : complete_run

    // one host request; a refused one shows its pulse on the edge that takes it
    task automatic send(input sfc_op_t op, input logic [11:0] pg, input logic [8:0] by,
                        input logic md, input logic rf, input logic hd, input logic [11:0] ep,
                        input logic [8:0] eb);
        int nv;
        nv = n_valid;
        // idle clock level settles a cycle ahead, so the select fall never races it
        @(posedge core_clk_in);
        mode3     <= md;
        @(posedge core_clk_in);
        start     <= 1'b1;
        opcode    <= op;
        page      <= pg;
        byte_addr <= by;
        @(posedge core_clk_in);
        start <= 1'b0;
        #1;
        chk("refused", {31'h0, rf}, {31'h0, refused});
        chk("busy", {31'h0, !rf}, {31'h0, busy});
        if (!rf) begin
            repeat (300) if (done !== 1'b1) begin
                @(posedge core_clk_in);
                #1;
            end
            chk("done", 1, {31'h0, done});
            repeat (3) @(posedge core_clk_in);
            #1;
            chk("pulses", nv + (hd ? 0 : 1), n_valid);
            chk("opcode", {24'h0, op}, {24'h0, dv_op});
            chk("mode3", {31'h0, md}, {31'h0, dv_m3});
            if (op != 8'h9f) chk("page", {20'h0, ep}, {20'h0, dv_page});
            if (op != 8'h9f) chk("byte", {23'h0, eb}, {23'h0, dv_byte});
        end
    endtask : send

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge core_clk_in);
        reset_in <= 1'b0;
        @(posedge core_clk_in);
        #1;
        chk("so_oe", 0, {31'h0, spi.so_oe});
        repeat (2) @(posedge core_clk_in);
        #1;
        chk("standby", 1, {31'h0, standby});
        @(posedge core_clk_in);
        por <= 1'b1;
        repeat (3) @(posedge core_clk_in);
        #1;
        chk("standby", 0, {31'h0, standby});
        @(posedge core_clk_in);
        por <= 1'b0;
        repeat (3) @(posedge core_clk_in);
        #1;
        chk("standby", 1, {31'h0, standby});
        send(8'h03, 12'h001, 9'h001, 1'b0, 1'b1, 1'b0, 12'h0, 9'h0);
        repeat (100) if (ready !== 1'b1) @(posedge core_clk_in);
        send(8'h02, 12'h001, 9'h001, 1'b0, 1'b1, 1'b0, 12'h0, 9'h0);
        @(posedge core_clk_in);
        tx_en <= 1'b1;
        send(8'h9f, 12'h000, 9'h000, 1'b1, 1'b0, 1'b0, 12'h0, 9'h0);
        chk("rx_byte", 32'ha5, {24'h0, rx_byte});
        send(8'h03, 12'habc, 9'h155, 1'b0, 1'b0, 1'b0, 12'habc, 9'h155);
        send(8'h0b, 12'hfff, 9'h1ff, 1'b1, 1'b0, 1'b0, 12'hfff, 9'h1ff);
        repeat (400) if (prog_ready !== 1'b1) @(posedge core_clk_in);
        send(8'h50, 12'habf, 9'h1ff, 1'b0, 1'b0, 1'b0, 12'habc, 9'h000);
        send(8'h02, 12'h123, 9'h0aa, 1'b1, 1'b0, 1'b0, 12'h123, 9'h0aa);
        // restart the device start-up timer while the host window stays open
        @(posedge core_clk_in);
        por <= 1'b1;
        @(posedge core_clk_in);
        por <= 1'b0;
        repeat (3) @(posedge core_clk_in);
        send(8'h02, 12'h321, 9'h00f, 1'b0, 1'b0, 1'b1, 12'h321, 9'h00f);
        nh = n_valid;
        chk("prog_ok", 0, {31'h0, prog_ok});
        repeat (250) if (prog_ok !== 1'b1) begin
            @(posedge core_clk_in);
            #1;
        end
        repeat (2) @(posedge core_clk_in);
        #1;
        chk("held_pulse", nh + 1, n_valid);
        chk("prog_ok", 1, {31'h0, prog_ok});
        complete_run();
    end
endmodule : serial_flash_powerup_cmd_front_bench

/* File: sfc_asserts.sv */
// link checker for the serial flash command front
`timescale 1ns/100ps
module sfc_asserts (
    // clock and reset
    input  wire logic core_clk_in,
    input  wire logic reset_in,
    // serial link
    input  wire logic sclk,
    input  wire logic si,
    input  wire logic select_n_pin,
    input  wire logic so_data,
    input  wire logic so_oe
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (reset_in);
    logic       sclk_q;
    logic [5:0] rise_q;
    logic [5:0] rise_d;

    // ------------------------------------------------------------
    // rising clocks per frame
    // ------------------------------------------------------------
    // cleared while deselected so an aborted frame cannot leak a count
    always_comb begin
        rise_d = select_n_pin ? 6'h00 : rise_q + {5'h00, sclk & ~sclk_q};
    end
    always_ff @(posedge core_clk_in) begin
        sclk_q <= sclk;
        rise_q <= reset_in ? 6'h00 : rise_d;
    end

    // ------------------------------------------------------------
    // link properties
    // ------------------------------------------------------------
    AST_SO_FLOAT_RESET:
        assert property (disable iff (1'b0) reset_in |=> !so_oe)
        else $error("serial output driven after reset");
    AST_SO_FLOAT_IDLE:
        assert property ($past(select_n_pin, 2) && $past(select_n_pin) && select_n_pin |-> !so_oe)
        else $error("serial output driven while deselected");
    AST_HOST_IDLE_RESET:
        assert property (disable iff (1'b0) reset_in |=> select_n_pin && !sclk)
        else $error("host link not idle after reset");
    AST_SELECT_HIGH_GAP:
        assert property ($rose(select_n_pin) |=> select_n_pin)
        else $error("select high for less than two cycles");
    AST_FRAME_BITS:
        assert property ($rose(select_n_pin) |-> rise_q == 6'h08 || rise_q == 6'h20)
        else $error("frame length not 8 or 32 bits");
    AST_SI_STABLE_HIGH:
        assert property (!select_n_pin && $past(!select_n_pin) && sclk && $past(sclk) |-> $stable(si))
        else $error("serial input moved while clock high");
    AST_SCLK_HIGH_HOLD:
        assert property ($rose(sclk) && !select_n_pin |=> sclk)
        else $error("clock high phase too short");
    AST_SCLK_LOW_HOLD:
        assert property ($fell(sclk) && !select_n_pin |=> !sclk)
        else $error("clock low phase too short");
    cover property ($rose(select_n_pin) && rise_q == 6'h20);
    cover property ($fell(select_n_pin) && sclk);
    cover property (so_oe && !select_n_pin);
endmodule : sfc_asserts

/* File: sfc_device.sv */
// flash device end: power-on state, mode pick and command entry
`timescale 1ns/100ps
module sfc_device
    import sfc_pkg::*;
#(
    parameter int unsigned PUW_CYC = sfc_pkg::PUW_CYCLES
) (
    // clock and reset
    input  wire logic                  core_clk_in,
    input  wire logic                  reset_in,
    input  wire logic                  power_on_reset_in,
    // serial link
    sfc_spi_if.device                  spi,
    // read data to send
    input  wire logic [7:0]            tx_byte_in,
    input  wire logic                  tx_enable_in,
    // decoded command
    output logic                       cmd_valid_out,
    output sfc_pkg::sfc_op_t           opcode_out,
    output logic [sfc_pkg::PAGE_W-1:0] page_out,
    output logic [sfc_pkg::BYTE_W-1:0] byte_out,
    output logic                       mode3_out,
    output logic                       standby_out,
    output logic                       prog_allowed_out
);

    // ------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------
    if (PUW_CYC < 1 || PUW_CYC > 32'h000f_ffff) begin : g_chk
        $error("PUW_CYC out of range for 20-bit counter");
    end

    typedef enum logic [1:0] {ST_POR, ST_STANDBY, ST_SHIFT, ST_HOLD} sfc_dev_st_t;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    sfc_dev_st_t         st_q,     st_d;
    logic                sel_q,    sel_d;
    logic                sclk_q,   sclk_d;
    logic                mode3_q,  mode3_d;
    logic [FRAME_W-1:0]  sh_q,     sh_d;
    logic [5:0]          cnt_q,    cnt_d;
    logic [19:0]         puw_q,    puw_d;
    logic                pdone_q,  pdone_d;
    logic                pend_q,   pend_d;
    logic                valid_q,  valid_d;
    sfc_op_t             op_q,     op_d;
    logic [PAGE_W-1:0]   page_q,   page_d;
    logic [BYTE_W-1:0]   byte_q,   byte_d;
    logic [7:0]          tx_q,     tx_d;
    logic                so_q,     so_d;
    logic                oe_q,     oe_d;

    logic                sel_fall;
    logic                sck_rise;
    logic                sck_fall;
    logic [FRAME_W-1:0]  sh_n;
    sfc_op_t             op_n;
    logic                finish;

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        sel_fall = sel_q & ~spi.select_n_pin;
        sck_rise = spi.sclk & ~sclk_q;
        sck_fall = ~spi.sclk & sclk_q;
        sh_n     = {sh_q[FRAME_W-2:0], spi.si};
        op_n     = (cnt_q == OP_LAST) ? sh_n[OP_W-1:0] : sh_n[FRAME_W-1:ADDR_W];
        finish   = 1'b0;
        st_d     = st_q;
        sel_d    = spi.select_n_pin;
        sclk_d   = spi.sclk;
        mode3_d  = mode3_q;
        sh_d     = sh_q;
        cnt_d    = cnt_q;
        pend_d   = pend_q;
        valid_d  = 1'b0;
        op_d     = op_q;
        page_d   = page_q;
        byte_d   = byte_q;
        tx_d     = tx_q;
        so_d     = so_q;
        oe_d     = 1'b0;
        // start-up timer runs from power-on reset release
        puw_d    = puw_q;
        pdone_d  = pdone_q;
        if (!pdone_q) begin
            puw_d   = puw_q + 20'h00001;
            pdone_d = (puw_q == 20'(PUW_CYC - 1));
        end
        // held program/erase starts once the delay is over
        if (pend_q && pdone_q) begin
            pend_d  = 1'b0;
            valid_d = 1'b1;
        end
        case (st_q)
            ST_POR: begin
                st_d = ST_STANDBY;
            end
            ST_STANDBY: begin
                // only a select fall opens an instruction
                if (sel_fall) begin
                    mode3_d = spi.sclk;
                    cnt_d   = 6'h00;
                    st_d    = ST_SHIFT;
                    // mode 0 needs bit 7 before the first rising edge
                    so_d    = spi.sclk ? 1'b0 : tx_byte_in[7];
                    tx_d    = spi.sclk ? tx_byte_in : {tx_byte_in[6:0], 1'b0};
                end
            end
            ST_SHIFT: begin
                oe_d = tx_enable_in & ~spi.select_n_pin;
                if (spi.select_n_pin) begin
                    st_d = ST_STANDBY;  // short frame is dropped
                end else if (sck_rise) begin
                    sh_d  = sh_n;
                    cnt_d = cnt_q + 6'h01;
                    if (cnt_q == FRM_LAST) begin
                        finish = 1'b1;
                    end else if (cnt_q == OP_LAST && !sfc_has_addr(op_n)) begin
                        finish = 1'b1;
                    end
                end else if (sck_fall) begin
                    // output changes on the falling edge in both modes
                    so_d = tx_q[7];
                    tx_d = {tx_q[6:0], 1'b0};
                end
                if (finish) begin
                    op_d   = op_n;
                    // dummy positions never reach the command logic
                    page_d = sh_n[PAGE_LSB +: PAGE_W] & sfc_page_mask(op_n);
                    byte_d = sh_n[BYTE_W-1:0] & sfc_byte_mask(op_n);
                    if (!sfc_has_addr(op_n)) begin
                        page_d = '0;
                        byte_d = '0;
                    end
                    if (sfc_is_prog_erase(op_n) && !pdone_q) begin
                        pend_d = 1'b1;
                    end else begin
                        valid_d = 1'b1;
                    end
                    st_d = ST_HOLD;
                end
            end
            ST_HOLD: begin
                // trailing clocks only shift the output byte until deselect
                oe_d = tx_enable_in & ~spi.select_n_pin;
                if (spi.select_n_pin) begin
                    st_d = ST_STANDBY;
                end else if (sck_fall) begin
                    so_d = tx_q[7];
                    tx_d = {tx_q[6:0], 1'b0};
                end
            end
            default: begin
                st_d = ST_POR;
            end
        endcase
        // internal reset overrides every command and the output
        if (power_on_reset_in) begin
            st_d    = ST_POR;
            pend_d  = 1'b0;
            valid_d = 1'b0;
            oe_d    = 1'b0;
            puw_d   = 20'h00000;
            pdone_d = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            st_q    <= ST_POR;
            sel_q   <= 1'b1;
            sclk_q  <= 1'b0;
            mode3_q <= 1'b0;
            sh_q    <= '0;
            cnt_q   <= 6'h00;
            puw_q   <= 20'h00000;
            pdone_q <= 1'b0;
            pend_q  <= 1'b0;
            valid_q <= 1'b0;
            op_q    <= '0;
            page_q  <= '0;
            byte_q  <= '0;
            tx_q    <= 8'h00;
            so_q    <= 1'b0;
            oe_q    <= 1'b0;
        end else begin
            st_q    <= st_d;
            sel_q   <= sel_d;
            sclk_q  <= sclk_d;
            mode3_q <= mode3_d;
            sh_q    <= sh_d;
            cnt_q   <= cnt_d;
            puw_q   <= puw_d;
            pdone_q <= pdone_d;
            pend_q  <= pend_d;
            valid_q <= valid_d;
            op_q    <= op_d;
            page_q  <= page_d;
            byte_q  <= byte_d;
            tx_q    <= tx_d;
            so_q    <= so_d;
            oe_q    <= oe_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign spi.so_data       = so_q;
    assign spi.so_oe         = oe_q;
    assign cmd_valid_out     = valid_q;
    assign opcode_out        = op_q;
    assign page_out          = page_q;
    assign byte_out          = byte_q;
    assign mode3_out         = mode3_q;
    assign standby_out       = (st_q == ST_STANDBY);
    assign prog_allowed_out  = pdone_q;

endmodule : sfc_device

/* File: sfc_host.sv */
// host controller end: start-up waits, select and clock generation
`timescale 1ns/100ps
module sfc_host
    import sfc_pkg::*;
#(
    parameter int unsigned VCSL_CYC = sfc_pkg::VCSL_CYCLES,
    parameter int unsigned PUW_CYC  = sfc_pkg::PUW_CYCLES,
    parameter int unsigned HALF_DIV = sfc_pkg::HALF_DIV_DEFAULT
) (
    // clock and reset
    input  wire logic                  core_clk_in,
    input  wire logic                  reset_in,
    // serial link
    sfc_spi_if.host                    spi,
    // command request
    input  wire logic                  start_in,
    input  wire logic                  mode3_in,
    input  sfc_pkg::sfc_op_t           opcode_in,
    input  wire logic [sfc_pkg::PAGE_W-1:0] page_in,
    input  wire logic [sfc_pkg::BYTE_W-1:0] byte_in,
    // status
    output logic                       busy_out,
    output logic                       done_out,
    output logic                       refused_out,
    output logic                       ready_out,
    output logic                       prog_ready_out,
    output logic [7:0]                 rx_byte_out
);

    // ------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------
    if (HALF_DIV < 1 || HALF_DIV > 255 || VCSL_CYC < 1 || PUW_CYC < VCSL_CYC
        || PUW_CYC > 32'h000f_ffff) begin : g_chk
        $error("host timing parameters out of range");
    end

    typedef enum logic [1:0] {HS_IDLE, HS_SHIFT, HS_END} sfc_host_st_t;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    sfc_host_st_t        st_q,    st_d;
    logic [19:0]         up_q,    up_d;
    logic [7:0]          div_q,   div_d;
    logic                sck_q,   sck_d;
    logic                sel_q,   sel_d;
    logic                m3_q,    m3_d;
    logic                first_q, first_d;
    logic [FRAME_W-1:0]  sh_q,    sh_d;
    logic [5:0]          cnt_q,   cnt_d;
    logic [5:0]          last_q,  last_d;
    logic [7:0]          rx_q,    rx_d;
    logic                done_q,  done_d;
    logic                ref_q,   ref_d;

    logic                tick;
    logic                vcsl_ok;
    logic                puw_ok;

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        vcsl_ok = (up_q >= 20'(VCSL_CYC));
        puw_ok  = (up_q >= 20'(PUW_CYC));
        tick    = (div_q == 8'(HALF_DIV - 1));
        st_d    = st_q;
        up_d    = puw_ok ? up_q : up_q + 20'h00001;
        div_d   = tick ? 8'h00 : div_q + 8'h01;
        sck_d   = sck_q;
        sel_d   = sel_q;
        m3_d    = m3_q;
        first_d = first_q;
        sh_d    = sh_q;
        cnt_d   = cnt_q;
        last_d  = last_q;
        rx_d    = rx_q;
        done_d  = 1'b0;
        ref_d   = 1'b0;
        case (st_q)
            HS_IDLE: begin
                sck_d = mode3_in;  // idle level tells the device its mode
                if (start_in) begin
                    if (!vcsl_ok || (sfc_is_prog_erase(opcode_in) && !puw_ok)) begin
                        ref_d = 1'b1;
                    end else begin
                        sel_d   = 1'b0;
                        m3_d    = mode3_in;
                        first_d = mode3_in;
                        div_d   = 8'h00;
                        cnt_d   = 6'h00;
                        last_d  = sfc_has_addr(opcode_in) ? FRM_LAST : OP_LAST;
                        // dummy positions are sent as zero
                        sh_d    = {opcode_in, 3'b000,
                                   page_in & sfc_page_mask(opcode_in),
                                   byte_in & sfc_byte_mask(opcode_in)};
                        if (!sfc_has_addr(opcode_in)) begin
                            sh_d = {opcode_in, 24'h000000};
                        end
                        st_d    = HS_SHIFT;
                    end
                end
            end
            HS_SHIFT: begin
                if (tick) begin
                    sck_d = ~sck_q;
                    if (!sck_q) begin
                        // rising edge: device samples, host captures
                        rx_d  = {rx_q[6:0], spi.so_data};
                        cnt_d = cnt_q + 6'h01;
                        if (cnt_q == last_q) begin
                            st_d = HS_END;
                        end
                    end else if (first_q) begin
                        first_d = 1'b0;  // first mode 3 fall only opens
                    end else begin
                        sh_d = {sh_q[FRAME_W-2:0], 1'b0};
                    end
                end
            end
            HS_END: begin
                // return the clock to idle, then deselect
                if (tick) begin
                    if (sck_q != m3_q) begin
                        sck_d = m3_q;
                    end else begin
                        sel_d  = 1'b1;
                        done_d = 1'b1;
                        st_d   = HS_IDLE;
                    end
                end
            end
            default: begin
                st_d = HS_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            st_q    <= HS_IDLE;
            up_q    <= 20'h00000;
            div_q   <= 8'h00;
            sck_q   <= 1'b0;
            sel_q   <= 1'b1;
            m3_q    <= 1'b0;
            first_q <= 1'b0;
            sh_q    <= '0;
            cnt_q   <= 6'h00;
            last_q  <= 6'h00;
            rx_q    <= 8'h00;
            done_q  <= 1'b0;
            ref_q   <= 1'b0;
        end else begin
            st_q    <= st_d;
            up_q    <= up_d;
            div_q   <= div_d;
            sck_q   <= sck_d;
            sel_q   <= sel_d;
            m3_q    <= m3_d;
            first_q <= first_d;
            sh_q    <= sh_d;
            cnt_q   <= cnt_d;
            last_q  <= last_d;
            rx_q    <= rx_d;
            done_q  <= done_d;
            ref_q   <= ref_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign spi.sclk         = sck_q;
    assign spi.si           = sh_q[FRAME_W-1];
    assign spi.select_n_pin = sel_q;
    assign busy_out         = (st_q != HS_IDLE);
    assign done_out         = done_q;
    assign refused_out      = ref_q;
    assign ready_out        = (up_q >= 20'(VCSL_CYC));
    assign prog_ready_out   = (up_q >= 20'(PUW_CYC));
    assign rx_byte_out      = rx_q;

endmodule : sfc_host

/* File: sfc_pkg.sv */
// shared constants, opcode decode and timing for the serial flash command front
package sfc_pkg;

    // ------------------------------------------------------------
    // clock and start-up timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_MHZ          = 200;
    localparam int unsigned SUPPLY_TO_SELECT_WAIT_US        = 70;  // supply to select wait, least
    localparam int unsigned PROGRAM_ERASE_STARTUP_DELAY_MS         = 3;   // program/erase start-up, longest
    localparam int unsigned VCSL_CYCLES      = SUPPLY_TO_SELECT_WAIT_US * CLK_MHZ;
    localparam int unsigned PUW_CYCLES       = PROGRAM_ERASE_STARTUP_DELAY_MS * 1000 * CLK_MHZ;
    localparam int unsigned HALF_DIV_DEFAULT = 2;   // host clock half period, cycles

    // ------------------------------------------------------------
    // frame layout: opcode, 3 dummy, 12 page, 9 byte/buffer bits
    // ------------------------------------------------------------
    localparam int unsigned OP_W      = 8;
    localparam int unsigned PAGE_W    = 12;
    localparam int unsigned BYTE_W    = 9;
    localparam int unsigned ADDR_W    = 24;
    localparam int unsigned FRAME_W   = 32;
    localparam int unsigned PAGE_LSB  = 9;
    localparam int unsigned DUMMY_LSB = 21;
    localparam logic [5:0]  OP_LAST   = 6'h07;  // bit index of last opcode bit
    localparam logic [5:0]  FRM_LAST  = 6'h1f;  // bit index of last address bit

    typedef logic [OP_W-1:0] sfc_op_t;

    // opcodes that carry no address bytes
    function automatic logic sfc_has_addr(input sfc_op_t op);
        case (op)
            8'h9f, 8'hb9, 8'hab, 8'hd7, 8'h79: sfc_has_addr = 1'b0;
            default:                           sfc_has_addr = 1'b1;
        endcase
    endfunction : sfc_has_addr

    // page bits that are real address, the rest are dummy
    function automatic logic [PAGE_W-1:0] sfc_page_mask(input sfc_op_t op);
        case (op)
            8'h32, 8'h77, 8'h84, 8'h87, 8'hd1, 8'hd3, 8'hd4, 8'hd6: sfc_page_mask = 12'h000;
            8'h7c:   sfc_page_mask = 12'hf00;
            8'h50:   sfc_page_mask = 12'hffc;
            default: sfc_page_mask = 12'hfff;
        endcase
    endfunction : sfc_page_mask

    // byte/buffer bits that are real address
    function automatic logic [BYTE_W-1:0] sfc_byte_mask(input sfc_op_t op);
        case (op)
            8'h01, 8'h02, 8'h03, 8'h0b, 8'h1b, 8'h82, 8'h84, 8'h85, 8'h87,
            8'hd1, 8'hd2, 8'hd3, 8'hd4, 8'hd6: sfc_byte_mask = 9'h1ff;
            default:                           sfc_byte_mask = 9'h000;
        endcase
    endfunction : sfc_byte_mask

    // program and erase opcodes, gated by the start-up delay
    function automatic logic sfc_is_prog_erase(input sfc_op_t op);
        case (op)
            8'h02, 8'h50, 8'h58, 8'h59, 8'h7c, 8'h81, 8'h82, 8'h83,
            8'h85, 8'h86, 8'h88, 8'h89: sfc_is_prog_erase = 1'b1;
            default:                    sfc_is_prog_erase = 1'b0;
        endcase
    endfunction : sfc_is_prog_erase

endpackage : sfc_pkg

/* File: sfc_spi_if.sv */
// serial link between host controller and flash command front
`timescale 1ns/100ps
interface sfc_spi_if;
    logic sclk;          // serial clock, host driven
    logic si;            // serial data into device
    logic select_n_pin;  // active-low select
    logic so_data;       // device serial output level
    logic so_oe;         // high while device drives serial output

    // ------------------------------------------------------------
    // one view per party
    // ------------------------------------------------------------
    modport device (input sclk, input si, input select_n_pin, output so_data, output so_oe);
    modport host   (output sclk, output si, output select_n_pin, input so_data, input so_oe);
endinterface : sfc_spi_if
